/* File: rq_pkg.sv */
// shared constants and types for the read queue event logger
package rq_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00; // control bits
    localparam logic [7:0] ADDR_THRESH = 8'h04; // read-multiple threshold
    localparam logic [7:0] ADDR_STATUS = 8'h08; // queue state
    localparam logic [7:0] ADDR_TBASE = 8'h0c; // timebase rate in MHz
    localparam logic [7:0] ADDR_POP = 8'h10; // read pops one entry word set
    localparam logic [7:0] ADDR_ENT_TS = 8'h14; // head timestamp
    localparam logic [7:0] ADDR_ENT_ID = 8'h18; // head arbitration id
    localparam logic [7:0] ADDR_ENT_INFO = 8'h1c; // head type/length
    localparam logic [7:0] ADDR_ENT_DATA = 8'h20; // head bytes 0..3
    // ------------------------------------------------------------
    // control bit positions
    // ------------------------------------------------------------
    localparam int CTRL_START_LOG = 0; // log start trigger
    localparam int CTRL_FAULT_LOG = 1; // log transceiver faults
    localparam int CTRL_WARN_LOG = 2; // log comm warnings
    localparam int CTRL_SELF_RX = 3; // self reception
    localparam int CTRL_RUN = 4; // communication running
    localparam int CTRL_LIN = 5; // lin mode
    localparam int CTRL_USB = 6; // usb-class auto lock
    localparam int CTRL_PXI_REF = 7; // backplane ref routed to timebase
    // ------------------------------------------------------------
    // queue geometry and reset values
    // ------------------------------------------------------------
    localparam int QDEPTH = 16; // read queue length
    localparam int QAW = 4; // queue address width
    localparam logic [4:0] THRESH_RST = 5'd8; // half the queue length
    localparam logic [7:0] RATE_RST = 8'd20; // 20 mhz
    localparam logic [7:0] RATE_10 = 8'd10; // 10 mhz
    localparam logic [7:0] RATE_1 = 8'd1; // 1 mhz
    // ------------------------------------------------------------
    // entry codes
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_DATA = 4'h0; // ordinary frame
    localparam logic [3:0] TYPE_WARN = 4'h2; // comm warning
    localparam logic [3:0] TYPE_TRIG = 4'h6; // start trigger marker
    localparam logic [3:0] TYPE_FAULT = 4'h7; // transceiver fault
    localparam logic [3:0] LEN_FAULT = 4'h1; // fault payload length
    localparam logic [3:0] LEN_ZERO = 4'h0; // empty payload
    localparam logic [28:0] ID_FAULT = 29'h0; // fault arbitration id
    localparam logic [28:0] ID_WARN_FAULT = 29'h1; // warning id for a fault
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100; // pclk rate
    localparam int DEBOUNCE_MS = 10; // spacing of fault entries
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ; // 1,000,000
    // one queue entry
    typedef struct packed {
        logic [31:0] ts;
        logic [28:0] id;
        logic [3:0] ftype;
        logic [3:0] len;
        logic [31:0] data;
    } entry_t;
endpackage : rq_pkg

/* File: rq_sync.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module rq_sync
    import rq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_t;
    sync_t st_ff; // both stages
    sync_t nxt_st; // next stages
    // first stage feeds only the second
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end
    // registered stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign q = st_ff.s2;
endmodule : rq_sync

/* File: rq_fifo.sv */
// read queue storage with occupancy count
`timescale 1ns/1ps
module rq_fifo
    import rq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire entry_t wdata,
    input wire logic rd,
    output entry_t rdata,
    output logic [QAW:0] count
);
    typedef struct packed {
        logic [QAW-1:0] wp;
        logic [QAW-1:0] rp;
        logic [QAW:0] cnt;
    } fifo_t;
    fifo_t st_ff; // pointers and count
    fifo_t nxt_st; // next pointers
    entry_t mem [QDEPTH]; // entry storage
    logic do_wr; // write accepted
    logic do_rd; // read accepted
    // pointer and count update; full refuses writes
    always_comb begin
        do_wr = wr && (st_ff.cnt != 5'(QDEPTH));
        do_rd = rd && (st_ff.cnt != '0);
        nxt_st = st_ff;
        if (do_wr) begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (do_rd) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {4'd0, do_wr} - {4'd0, do_rd};
    end
    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // storage array, no reset needed
    always_ff @(posedge pclk) begin
        if (do_wr) begin
            mem[st_ff.wp] <= wdata;
        end
    end
    assign rdata = mem[st_ff.rp];
    assign count = st_ff.cnt;
endmodule : rq_fifo

/* File: bus_read_queue_event_logger.sv */
// read queue event logger: start markers, fault frames, self reception
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// - log start marker when communication starts
// - fault logging off by default
// - fault logging changeable while running
// - fault frame per error line change, debounced
// - fault frame: timestamp, id 0, type 7, length 1
// - byte 0 is fault present flag
// - timebase rate defaults to 20 mhz
// - backplane reference forces 10 mhz
// - usb class ignores setting, locks automatically
// - read-multiple flag at threshold, default half
// - self reception echoes transmitted frames
// - unacknowledged frames never echoed
// - self reception off by default
// - lin slave responses queued per self reception
// - warning logging stores type 2 length 0 outside lin mode
module bus_read_queue_event_logger
    import rq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic transceiver_error_line,
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic [3:0] rx_len,
    input wire logic [31:0] rx_data,
    input wire logic tx_done,
    input wire logic tx_acked,
    input wire logic [28:0] tx_id,
    input wire logic [3:0] tx_len,
    input wire logic [31:0] tx_data,
    input wire logic [1:0] sync_bus_clock_terminal,
    output logic multi_frame_read_threshold,
    output logic [7:0] timebase_rate_mhz,
    output logic comm_started,
    output logic queue_overflow
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // host settings and the effective rate
        logic [7:0] ctrl;
        logic [4:0] thresh;
        logic [7:0] rate_set;
        logic [7:0] rate;
        // free running timestamp and bus answer
        logic [31:0] ts;
        logic [31:0] rdata;
        logic ready;
        logic err;
        // event detection
        logic run_d;
        logic trig_pend;
        logic line_last;
        logic fault_pend;
        logic [19:0] deb;
        // status flags and pop strobe
        logic mrt;
        logic ovf;
        logic pop;
    } top_t;
    top_t st_ff; // all registers
    top_t nxt_st; // next value
    logic line_s; // synchronised error line
    entry_t q_head; // queue head entry
    logic [QAW:0] q_count; // entries held
    entry_t q_wdata; // entry to write
    logic q_wr; // write strobe
    logic acc; // apb access phase
    // ------------------------------------------------------------
    // timing notes
    // ------------------------------------------------------------
    // apb: setup edge, access edge, then pready for one cycle
    // the access edge is the only one that updates registers
    // read data is captured at the access edge and held after
    // a second access cannot start while pready is still high
    // queue writers, highest priority first:
    //   received frame from another node
    //   echo of an acknowledged transmit or lin response
    //   start trigger marker
    //   fault or warning entry
    // a blocked marker or fault waits in its pending flag
    // only one entry is written per cycle, so the free running
    // timestamp is strictly increasing through the queue
    // the error line passes two flops before the edge detector
    // a fault entry is written three to four cycles after the pin
    // the debounce counter blocks a new change for its full span
    // a change during that span is taken once the count ends
    // pop reads advance the head one cycle after the access
    // the head words always show the entry at the read pointer
    // an empty queue shows stale storage on the head words
    // rate: backplane reference beats the usb lock,
    // and either beats the host setting
    // the rate output follows one cycle after its cause
    // overflow stays set until the host writes the pop word
    // the threshold compare uses the registered count,
    // so the flag trails the count by one cycle
    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    // error line comes from the pin, two flops first
    rq_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(transceiver_error_line),
        .q(line_s)
    );
    // sixteen entry read queue
    rq_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .wr(q_wr),
        .wdata(q_wdata),
        .rd(st_ff.pop),
        .rdata(q_head),
        .count(q_count)
    );
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // hold every field unless a branch below changes it
        nxt_st = st_ff;
        q_wr = 1'b0;
        q_wdata = '0;
        // access phase is taken once, pready blocks a repeat
        acc = psel && penable && !st_ff.ready;
        nxt_st.ready = acc;
        nxt_st.err = 1'b0;
        nxt_st.pop = 1'b0;
        // free running timestamp
        nxt_st.ts = st_ff.ts + 32'd1;
        nxt_st.run_d = st_ff.ctrl[CTRL_RUN];
        // apb register access, one wait state
        if (acc) begin
            nxt_st.rdata = '0;
            unique case (paddr)
                // control bits, read back as written
                ADDR_CTRL: begin
                    nxt_st.rdata = {24'd0, st_ff.ctrl};
                    if (pwrite) begin
                        nxt_st.ctrl = pwdata[7:0];
                    end
                end
                // read-multiple threshold, five bits
                ADDR_THRESH: begin
                    nxt_st.rdata = {27'd0, st_ff.thresh};
                    if (pwrite) begin
                        nxt_st.thresh = pwdata[4:0];
                    end
                end
                // status is read only
                ADDR_STATUS: nxt_st.rdata = {25'd0, st_ff.ovf, st_ff.mrt, q_count};
                // effective rate above, setting below
                ADDR_TBASE: begin
                    nxt_st.rdata = {16'd0, st_ff.rate, st_ff.rate_set};
                    if (pwrite) begin
                        nxt_st.rate_set = pwdata[7:0];
                    end
                end
                ADDR_POP: begin
                    // read pops the head, write clears overflow
                    nxt_st.pop = !pwrite;
                    if (pwrite) begin
                        nxt_st.ovf = 1'b0;
                    end
                end
                // head entry words, read only
                ADDR_ENT_TS: nxt_st.rdata = q_head.ts;
                ADDR_ENT_ID: nxt_st.rdata = {3'd0, q_head.id};
                ADDR_ENT_INFO: nxt_st.rdata = {24'd0, q_head.len, q_head.ftype};
                ADDR_ENT_DATA: nxt_st.rdata = q_head.data;
                // unmapped or misaligned address
                default: nxt_st.err = 1'b1;
            endcase
        end
        // run bit rising with start logging set
        // marker on start of communication
        if (st_ff.ctrl[CTRL_RUN] && !st_ff.run_d && st_ff.ctrl[CTRL_START_LOG]) begin
            nxt_st.trig_pend = 1'b1;
        end
        // count down to zero, then hold
        // debounce counter spaces fault entries
        if (st_ff.deb != '0) begin
            nxt_st.deb = st_ff.deb - 20'd1;
        end
        // a change is taken only while the counter is idle
        // warning logging also needs the event, as a type 2 entry outside lin mode
        // disabled logging drops fault events
        if (line_s != st_ff.line_last && st_ff.deb == '0) begin
            nxt_st.line_last = line_s;
            nxt_st.deb = 20'(DEBOUNCE_CYC - 1);
            nxt_st.fault_pend = st_ff.ctrl[CTRL_FAULT_LOG] || st_ff.ctrl[CTRL_WARN_LOG];
        end
        // queue write arbitration, one writer per cycle
        // one entry per cycle, arrival order is timestamp order
        if (rx_valid) begin
            q_wr = 1'b1;
            q_wdata = '{ts: st_ff.ts, id: rx_id, ftype: TYPE_DATA, len: rx_len, data: rx_data};
        // echo transmitted frames; lin slave responses alike
        end else if (tx_done && tx_acked && st_ff.ctrl[CTRL_SELF_RX]) begin
            // unacknowledged frames excluded; off by default
            q_wr = 1'b1;
            q_wdata = '{ts: st_ff.ts, id: tx_id, ftype: TYPE_DATA, len: tx_len, data: tx_data};
        end else if (st_ff.trig_pend) begin
            q_wr = 1'b1;
            nxt_st.trig_pend = 1'b0;
            q_wdata = '{ts: st_ff.ts, id: '0, ftype: TYPE_TRIG, len: LEN_ZERO, data: '0};
        end else if (st_ff.fault_pend) begin
            q_wr = 1'b1;
            nxt_st.fault_pend = 1'b0;
            // warning format only applies to can mode
            if (st_ff.ctrl[CTRL_WARN_LOG] && !st_ff.ctrl[CTRL_LIN]) begin
                // warning frame type 2 length 0
                q_wdata = '{ts: st_ff.ts, id: ID_WARN_FAULT, ftype: TYPE_WARN, len: LEN_ZERO, data: '0};
            end else begin
                // fault frame layout; byte 0 fault flag
                q_wdata = '{ts: st_ff.ts, id: ID_FAULT, ftype: TYPE_FAULT, len: LEN_FAULT,
                            data: {7'd0, st_ff.line_last, 24'd0}};
            end
        end
        // a write into a full queue is dropped by the storage
        // overflow flag, set wins over clear
        if (q_wr && q_count == 5'(QDEPTH)) begin
            nxt_st.ovf = 1'b1;
        end
        // threshold zero keeps the flag low
        // read-multiple state at threshold
        nxt_st.mrt = (q_count >= st_ff.thresh) && (st_ff.thresh != '0);
        if (st_ff.ctrl[CTRL_PXI_REF]) begin
            nxt_st.rate = RATE_10;
        // usb class locks to the detected rate
        end else if (st_ff.ctrl[CTRL_USB]) begin
            unique case (sync_bus_clock_terminal)
                // detected code 1 is 1 mhz, 2 is 10 mhz
                2'd1: nxt_st.rate = RATE_1;
                2'd2: nxt_st.rate = RATE_10;
                // anything else is taken as 20 mhz
                default: nxt_st.rate = RATE_RST;
            endcase
        end else begin
            // otherwise the host setting applies
            nxt_st.rate = st_ff.rate_set;
        end
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // all fields reset to zero except threshold and rates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.thresh <= THRESH_RST;
            st_ff.rate_set <= RATE_RST;
            st_ff.rate <= RATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a register field, no logic after the flops
    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.err;
    assign multi_frame_read_threshold = st_ff.mrt;
    assign timebase_rate_mhz = st_ff.rate;
    assign comm_started = st_ff.run_d;
    assign queue_overflow = st_ff.ovf;
endmodule : bus_read_queue_event_logger

/* File: rq_logger_asserts.sv */
// port assertions for the read queue event logger
`timescale 1ns/1ps
module rq_logger_asserts
    import rq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] sync_bus_clock_terminal,
    input wire logic multi_frame_read_threshold,
    input wire logic [7:0] timebase_rate_mhz,
    input wire logic comm_started,
    input wire logic queue_overflow
);
    // ------
    // bus timing
    // ------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_map_a: assert property (pready |-> pslverr == (paddr > ADDR_ENT_DATA || paddr[1:0] != 2'b00))
        else $error("pslverr does not match address map");
    // ------
    // reset and hold
    // ------
    rate_reset_a: assert property ($rose(presetn) |-> timebase_rate_mhz == RATE_RST)
        else $error("timebase rate not 20 after reset");
    reset_quiet_a: assert property ($rose(presetn) |-> !multi_frame_read_threshold && !comm_started)
        else $error("flags set after reset");
    run_stable_a: assert property (!(psel && pwrite && paddr == ADDR_CTRL) [*3] |=> $stable(comm_started))
        else $error("run changed without control write");
    rate_stable_a: assert property ((!(psel && pwrite) && $stable(sync_bus_clock_terminal)) [*3]
        |=> $stable(timebase_rate_mhz))
        else $error("rate changed without cause");
    ovf_hold_a: assert property (queue_overflow && !(psel && pwrite && paddr == ADDR_POP) |=> queue_overflow)
        else $error("overflow cleared without write");
endmodule : rq_logger_asserts

bind bus_read_queue_event_logger rq_logger_asserts i_rq_logger_asserts (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .sync_bus_clock_terminal, .multi_frame_read_threshold,
    .timebase_rate_mhz, .comm_started, .queue_overflow);

/* File: bus_node_model.sv */
// model of the other bus nodes and the transceiver
`timescale 1ns/1ps
module bus_node_model (
    input wire logic pclk,
    output logic transceiver_error_line,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic [3:0] rx_len,
    output logic [31:0] rx_data,
    output logic tx_done,
    output logic tx_acked,
    output logic [28:0] tx_id,
    output logic [3:0] tx_len,
    output logic [31:0] tx_data
);
    // idle levels at time zero
    initial begin
        {transceiver_error_line, rx_valid, rx_id, rx_len, rx_data} = '0;
        {tx_done, tx_acked, tx_id, tx_len, tx_data} = '0;
    end
    // transceiver fault line level
    task automatic set_fault(input logic v);
        @(posedge pclk);
        transceiver_error_line <= v;
    endtask : set_fault
    // frame sent by another node, lines scrambled after
    task automatic send_rx(input logic [28:0] id);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_len <= 4'h4;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_len <= 4'hb;
    endtask : send_rx
    task automatic send_tx(input logic [28:0] id, input logic ack);
        @(posedge pclk);
        tx_done <= 1'b1;
        tx_acked <= ack;
        tx_id <= id;
        tx_len <= 4'h2;
        @(posedge pclk);
        tx_done <= 1'b0;
        tx_acked <= ~ack;
        tx_id <= ~id;
    endtask : send_tx
endmodule : bus_node_model

/* File: bus_read_queue_event_logger_tb.sv */
// self-checking bench for the read queue event logger
`timescale 1ns/1ps
module bus_read_queue_event_logger_tb
    import rq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, timebase_rate_mhz;
    logic [31:0] pwdata, prdata, rx_data, tx_data, r, t1;
    logic transceiver_error_line, rx_valid, tx_done, tx_acked;
    logic [28:0] rx_id, tx_id;
    logic [3:0] rx_len, tx_len;
    logic [1:0] sync_bus_clock_terminal;
    logic multi_frame_read_threshold, comm_started, queue_overflow;
    int mismatches, compares;
    bus_read_queue_event_logger i_bus_read_queue_event_logger (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .transceiver_error_line, .rx_valid, .rx_id, .rx_len,
        .rx_data, .tx_done, .tx_acked, .tx_id, .tx_len, .tx_data, .sync_bus_clock_terminal,
        .multi_frame_read_threshold, .timebase_rate_mhz, .comm_started, .queue_overflow);
    bus_node_model i_bus_node_model (.pclk, .transceiver_error_line, .rx_valid, .rx_id, .rx_len, .rx_data,
        .tx_done, .tx_acked, .tx_id, .tx_len, .tx_data);
    // clock
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    // ------
    // tasks
    // ------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rdc
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        give_verdict();
    end
    // ------
    // tests
    // ------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sync_bus_clock_terminal} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_CTRL, 32'h0);
        rdc(ADDR_THRESH, 32'h8);
        rdc(ADDR_TBASE, 32'h1414);
        apb(1'b0, 8'h24, 32'h0);
        chk(e, 1'b1);
        // echo off: acked transmit stays out
        wr(ADDR_CTRL, 32'h10);
        i_bus_node_model.send_tx(29'h55, 1'b1);
        rdc(ADDR_STATUS, 32'h0);
        // marker, echo, unacked transmit dropped
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_THRESH, 32'h2);
        wr(ADDR_CTRL, 32'h9);
        wr(ADDR_CTRL, 32'h19);
        i_bus_node_model.send_tx(29'h123, 1'b1);
        i_bus_node_model.send_tx(29'h124, 1'b0);
        rdc(ADDR_STATUS, 32'h22);
        chk(comm_started, 1'b1);
        chk(multi_frame_read_threshold, 1'b1);
        rdc(ADDR_ENT_INFO, 32'h6);
        apb(1'b0, ADDR_ENT_TS, 32'h0);
        t1 = r;
        apb(1'b0, ADDR_POP, 32'h0);
        rdc(ADDR_ENT_ID, 32'h123);
        rdc(ADDR_ENT_INFO, 32'h20);
        apb(1'b0, ADDR_ENT_TS, 32'h0);
        chk(r > t1, 1'b1);
        apb(1'b0, ADDR_POP, 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        // fault logging turned on while running
        wr(ADDR_CTRL, 32'h12);
        i_bus_node_model.set_fault(1'b1);
        repeat (8) @(posedge pclk);
        rdc(ADDR_ENT_ID, 32'h0);
        rdc(ADDR_ENT_INFO, 32'h17);
        apb(1'b0, ADDR_ENT_DATA, 32'h0);
        chk(r[31:24], 8'h1);
        apb(1'b0, ADDR_POP, 32'h0);
        // lin slave responses
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h30);
        i_bus_node_model.send_tx(29'h21, 1'b1);
        rdc(ADDR_STATUS, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h28);
        wr(ADDR_CTRL, 32'h38);
        i_bus_node_model.send_tx(29'h22, 1'b1);
        rdc(ADDR_ENT_ID, 32'h22);
        apb(1'b0, ADDR_POP, 32'h0);
        // fill until refused, then clear overflow
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h10);
        for (int i = 0; i < 17; i++) i_bus_node_model.send_rx(29'(i));
        rdc(ADDR_STATUS, 32'h70);
        chk(queue_overflow, 1'b1);
        wr(ADDR_POP, 32'h0);
        rdc(ADDR_STATUS, 32'h30);
        // timebase overrides
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_TBASE, 32'ha);
        wr(ADDR_CTRL, 32'h10);
        rdc(ADDR_TBASE, 32'h0a0a);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_TBASE, 32'h5);
        wr(ADDR_CTRL, 32'h80);
        rdc(ADDR_TBASE, 32'ha05);
        wr(ADDR_CTRL, 32'h40);
        for (int k = 1; k < 4; k++) begin
            sync_bus_clock_terminal <= 2'(k);
            repeat (2) @(posedge pclk);
            rdc(ADDR_TBASE, {16'h0, (k == 1) ? 8'h1 : (k == 2) ? 8'ha : 8'h14, 8'h5});
        end
        chk(timebase_rate_mhz, 8'h14);
        give_verdict();
    end
endmodule : bus_read_queue_event_logger_tb
